// ---- design/fls_consts.svh ----
// constants for the flash lock/status host controller: offsets, fields, commands, timing
`ifndef FLS_CONSTS_SVH
`define FLS_CONSTS_SVH

// =====================================================================
// device command codes
`define FLS_CMD_READ_STATUS      8'h70
`define FLS_CMD_READ_ARRAY       8'hFF
`define FLS_CMD_CONFIRM          8'hD0
`define FLS_CMD_BUF_SETUP        8'hE8
`define FLS_CMD_CLEAR_STATUS     8'h50
`define FLS_CMD_LOCK_CLEAR_SETUP 8'h60
`define FLS_CMD_STS_CONFIG       8'hB8

// =====================================================================
// operation status bit positions and masks
`define FLS_SR_READY      7
`define FLS_SR_ERASE_ERR  5
`define FLS_SR_WRITE_ERR  4
`define FLS_SR_VLOW       3
`define FLS_SR_PROTECT    1
`define FLS_SR_VALID_MASK 8'hFE
`define FLS_SR_BUSY_MASK  8'h80
`define FLS_XSR_MASK      8'h80
`define FLS_STS_CODE_MAX  8'h03

// =====================================================================
// register word indices on the avalon slave
`define FLS_REG_CTRL   3'h0
`define FLS_REG_CONFIG 3'h1
`define FLS_REG_STATUS 3'h2
`define FLS_REG_SR     3'h3
`define FLS_REG_XSR    3'h4

// =====================================================================
// field positions
`define FLS_CTRL_OP_LSB    0
`define FLS_CTRL_CODE_LSB  8
`define FLS_CFG_WP_BIT     0
`define FLS_CFG_RP_BIT     1
`define FLS_CFG_AUTOCLR_BIT 2
`define FLS_CONFIG_RESET   3'h0

// =====================================================================
// bus timing, ns and derived 125 MHz cycles (minimums round up)
`define FLS_CLK_PERIOD_NS  8
`define FLS_T_SETUP_NS     20
`define FLS_T_STROBE_NS    100
`define FLS_T_READ_NS      120
`define FLS_T_HOLD_NS      20
`define FLS_CYC(t)         (((t) + `FLS_CLK_PERIOD_NS - 1) / `FLS_CLK_PERIOD_NS)
`define FLS_ADDR_W         21

`endif

// ---- design/fls_pkg.sv ----
// types shared by the flash lock/status host controller
package fls_pkg;

  // =====================================================================
  // software operations, coded in the order listed
  typedef enum logic [2:0] {
    OP_READ_STATUS, OP_CLEAR_STATUS, OP_CLEAR_LOCKS, OP_STS_CONFIG, OP_READ_ARRAY, OP_PROBE_BUFFER
  } fls_op_t;

  // status pin modes as configured in the device
  typedef enum logic [1:0] {STS_LEVEL, STS_PULSE_ERASE, STS_PULSE_WRITE, STS_PULSE_ANY} fls_sts_mode_t;

  // host sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD1, ST_CMD2, ST_WAIT_STS, ST_READ, ST_CHECK, ST_CLEAR
  } fls_state_t;

  // bus cycle phases
  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} fls_phase_t;

endpackage : fls_pkg

// ---- design/fls_bus_cycle.sv ----
// one sram-style write or read cycle on the flash pins
`timescale 1ns/100ps
`include "fls_consts.svh"
module fls_bus_cycle (
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       start_i,
  input  wire logic       write_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [7:0] dq_i,
  output logic            done_o,
  output logic [7:0]      rdata_o,
  output logic            ce_n_o,
  output logic            we_n_o,
  output logic            oe_n_o,
  output logic [7:0]      dq_o,
  output logic            dq_oe_o
);
  import fls_pkg::*;

  localparam logic [4:0] SETUP_CYC = 5'(`FLS_CYC(`FLS_T_SETUP_NS));
  localparam logic [4:0] WR_CYC    = 5'(`FLS_CYC(`FLS_T_STROBE_NS));
  localparam logic [4:0] RD_CYC    = 5'(`FLS_CYC(`FLS_T_READ_NS));
  localparam logic [4:0] HOLD_CYC  = 5'(`FLS_CYC(`FLS_T_HOLD_NS));

  fls_phase_t phase_reg;
  logic [4:0] cnt_reg;
  logic       wr_reg;

  // =====================================================================
  // phase sequencer; data held through hold phase so the device latches on we rise
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_reg <= PH_IDLE;
      cnt_reg   <= 5'h0;
      wr_reg    <= 1'b0;
      done_o    <= 1'b0;
      rdata_o   <= 8'h0;
      ce_n_o    <= 1'b1;
      we_n_o    <= 1'b1;
      oe_n_o    <= 1'b1;
      dq_o      <= 8'h0;
      dq_oe_o   <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (phase_reg)
        PH_IDLE: if (start_i) begin
          phase_reg <= PH_SETUP;
          cnt_reg   <= SETUP_CYC;
          wr_reg    <= write_i;
          ce_n_o    <= 1'b0;
          dq_o      <= wdata_i;
          dq_oe_o   <= write_i;
        end
        PH_SETUP: if (cnt_reg == 5'h1) begin
          phase_reg <= PH_STROBE;
          cnt_reg   <= wr_reg ? WR_CYC : RD_CYC;
          we_n_o    <= !wr_reg;
          oe_n_o    <= wr_reg;
        end else cnt_reg <= cnt_reg - 5'h1;
        PH_STROBE: if (cnt_reg == 5'h1) begin
          phase_reg <= PH_HOLD;
          cnt_reg   <= HOLD_CYC;
          we_n_o    <= 1'b1;
          oe_n_o    <= 1'b1;
          if (!wr_reg) rdata_o <= dq_i;  // sampled at end of access time
        end else cnt_reg <= cnt_reg - 5'h1;
        PH_HOLD: if (cnt_reg == 5'h1) begin
          phase_reg <= PH_IDLE;
          ce_n_o    <= 1'b1;
          dq_oe_o   <= 1'b0;
          done_o    <= 1'b1;
        end else cnt_reg <= cnt_reg - 5'h1;
      endcase
    end
  end
endmodule : fls_bus_cycle

// ---- design/fls_sts_watch.sv ----
// watches the device status pin in level or pulse mode
`timescale 1ns/100ps
module fls_sts_watch (
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  sts_i,
  input  fls_pkg::fls_sts_mode_t     mode_i,
  output logic                       ready_o,
  output logic                       pulse_o
);
  import fls_pkg::*;

  logic pin_reg;

  // =====================================================================
  // pin reads high when released; pull-up assumed on the board
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_reg <= 1'b1;
      ready_o <= 1'b0;
      pulse_o <= 1'b0;
    end else begin
      pin_reg <= sts_i;
      ready_o <= (mode_i == STS_LEVEL) && pin_reg;            // low means busy
      pulse_o <= (mode_i != STS_LEVEL) && !pin_reg && sts_i;  // end of a low pulse
    end
  end
endmodule : fls_sts_watch

// ---- design/fls_ctrl.sv ----
// host controller for flash lock clearing, status pin setup and status reads
`timescale 1ns/100ps
`include "fls_consts.svh"
module fls_ctrl (
  input  wire logic                   core_clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic [2:0]             avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  output logic      [31:0]            avs_readdata_o,
  output logic                        avs_waitrequest_o,
  output logic      [`FLS_ADDR_W-1:0] flash_addr_o,
  output logic                        flash_ce_n_o,
  output logic                        flash_we_n_o,
  output logic                        flash_oe_n_o,
  output logic      [7:0]             flash_dq_o,
  output logic                        flash_dq_oe_o,
  input  wire logic [7:0]             flash_dq_i,
  output logic                        reset_powerdown_n_o,
  output logic                        flash_wp_o,
  input  wire logic                   status_output_pin_i
);
  import fls_pkg::*;

  fls_state_t    state_reg;
  fls_op_t       op_reg;
  fls_sts_mode_t sts_mode_reg;
  logic [7:0]    code_reg;
  logic [7:0]    sr_reg;
  logic [7:0]    xsr_reg;
  logic          go_reg;
  logic          launched_reg;
  logic          cyc_start_reg;
  logic          cyc_write_reg;
  logic [7:0]    cyc_data_reg;
  logic          auto_clear_reg;
  logic          rp_prev_reg;
  logic          seq_err_reg;
  logic          lock_unknown_reg;
  logic          refused_reg;
  logic          pulse_seen_reg;
  logic          cyc_done;
  logic [7:0]    cyc_rdata;
  logic          sts_ready;
  logic          sts_pulse;
  logic          ctrl_wr;
  logic          stat_wr;
  logic          busy;
  logic          refuse_set;
  logic          seq_err_set;

  // =====================================================================
  // helpers
  // bits 6..0 mean nothing while the machine is busy; bit 0 is reserved
  function automatic logic [7:0] sr_view(input logic [7:0] sr);
    sr_view = sr & (sr[`FLS_SR_READY] ? `FLS_SR_VALID_MASK : `FLS_SR_BUSY_MASK);
  endfunction : sr_view

  // both error bits together mark an improper command sequence
  function automatic logic is_seq_err(input logic [7:0] sr);
    is_seq_err = sr[`FLS_SR_ERASE_ERR] && sr[`FLS_SR_WRITE_ERR];
  endfunction : is_seq_err

  assign busy        = (state_reg != ST_IDLE) || go_reg;
  assign ctrl_wr     = avs_write_i && avs_waitrequest_o && (avs_address_i == `FLS_REG_CTRL);
  assign stat_wr     = avs_write_i && avs_waitrequest_o && (avs_address_i == `FLS_REG_STATUS);
  assign refuse_set  = ctrl_wr && (busy || !reset_powerdown_n_o
                       || (fls_op_t'(avs_writedata_i[`FLS_CTRL_OP_LSB +: 3]) == OP_STS_CONFIG
                           && avs_writedata_i[`FLS_CTRL_CODE_LSB +: 8] > `FLS_STS_CODE_MAX)
                       || (avs_writedata_i[`FLS_CTRL_OP_LSB +: 3] > 3'(OP_PROBE_BUFFER)));
  assign seq_err_set = (state_reg == ST_CHECK) && sr_reg[`FLS_SR_READY] && is_seq_err(sr_reg);

  // =====================================================================
  // bus cycle engine and status pin monitor
  fls_bus_cycle u_cycle (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .start_i    (cyc_start_reg),
    .write_i    (cyc_write_reg),
    .wdata_i    (cyc_data_reg),
    .dq_i       (flash_dq_i),
    .done_o     (cyc_done),
    .rdata_o    (cyc_rdata),
    .ce_n_o     (flash_ce_n_o),
    .we_n_o     (flash_we_n_o),
    .oe_n_o     (flash_oe_n_o),
    .dq_o       (flash_dq_o),
    .dq_oe_o    (flash_dq_oe_o)
  );

  fls_sts_watch u_sts (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .sts_i      (status_output_pin_i),
    .mode_i     (sts_mode_reg),
    .ready_o    (sts_ready),
    .pulse_o    (sts_pulse)
  );

  // =====================================================================
  // avalon slave: one wait cycle per access, then a one-cycle release
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
      go_reg            <= 1'b0;
      op_reg            <= OP_READ_STATUS;
      code_reg          <= 8'h00;
    end else begin
      go_reg <= 1'b0;
      if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b0;
        avs_readdata_o    <= 32'h0000_0000;
        if (avs_read_i) begin
          unique case (avs_address_i)
            `FLS_REG_CTRL:   avs_readdata_o <= {16'h0000, code_reg, 5'h00, op_reg};
            `FLS_REG_CONFIG: avs_readdata_o <= {29'h0000_0000, auto_clear_reg, reset_powerdown_n_o, flash_wp_o};
            `FLS_REG_STATUS: avs_readdata_o <= {25'h000_0000, sts_mode_reg, pulse_seen_reg, refused_reg,
                                                lock_unknown_reg, seq_err_reg, busy};
            `FLS_REG_SR:     avs_readdata_o <= {24'h00_0000, sr_view(sr_reg)};
            `FLS_REG_XSR:    avs_readdata_o <= {24'h00_0000, xsr_reg & `FLS_XSR_MASK};
            default:         avs_readdata_o <= 32'h0000_0000;  // unmapped reads as zero
          endcase
        end
        if (ctrl_wr && !refuse_set) begin
          op_reg   <= fls_op_t'(avs_writedata_i[`FLS_CTRL_OP_LSB +: 3]);
          code_reg <= avs_writedata_i[`FLS_CTRL_CODE_LSB +: 8];
          go_reg   <= 1'b1;
        end
      end else begin
        avs_waitrequest_o <= 1'b1;
      end
    end
  end

  // =====================================================================
  // pin straps written by software; reset/power-down low also resets the device
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flash_wp_o          <= 1'b0;
      reset_powerdown_n_o <= 1'b0;
      auto_clear_reg      <= 1'b0;
      rp_prev_reg         <= 1'b0;
    end else begin
      rp_prev_reg <= reset_powerdown_n_o;
      if (avs_write_i && avs_waitrequest_o && avs_address_i == `FLS_REG_CONFIG) begin
        flash_wp_o          <= avs_writedata_i[`FLS_CFG_WP_BIT];
        reset_powerdown_n_o <= avs_writedata_i[`FLS_CFG_RP_BIT];
        auto_clear_reg      <= avs_writedata_i[`FLS_CFG_AUTOCLR_BIT];
      end
    end
  end

  // =====================================================================
  // sticky flags: hardware set wins over a software write-one clear
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seq_err_reg    <= 1'b0;
      refused_reg    <= 1'b0;
      pulse_seen_reg <= 1'b0;
    end else begin
      seq_err_reg    <= seq_err_set || (seq_err_reg && !(stat_wr && avs_writedata_i[1]));
      refused_reg    <= refuse_set || (refused_reg && !(stat_wr && avs_writedata_i[3]));
      pulse_seen_reg <= sts_pulse || (pulse_seen_reg && !(stat_wr && avs_writedata_i[4]));
    end
  end

  // =====================================================================
  // operation sequencer
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg        <= ST_IDLE;
      launched_reg     <= 1'b0;
      cyc_start_reg    <= 1'b0;
      cyc_write_reg    <= 1'b0;
      cyc_data_reg     <= 8'h00;
      sr_reg           <= 8'h00;
      xsr_reg          <= 8'h00;
      sts_mode_reg     <= STS_LEVEL;
      lock_unknown_reg <= 1'b0;
      flash_addr_o     <= '0;
    end else begin
      cyc_start_reg <= 1'b0;
      flash_addr_o  <= '0;  // every command here takes any address
      if (!reset_powerdown_n_o) begin
        // device reset: pin mode back to level, any clear in flight is lost
        sts_mode_reg <= STS_LEVEL;
        if (rp_prev_reg && state_reg != ST_IDLE && op_reg == OP_CLEAR_LOCKS) begin
          lock_unknown_reg <= 1'b1;
        end
        if (!launched_reg || cyc_done) begin
          state_reg    <= ST_IDLE;
          launched_reg <= 1'b0;
        end
      end else begin
        unique case (state_reg)
          ST_IDLE: if (go_reg) begin
            state_reg <= ST_CMD1;
          end
          ST_CMD1: if (!launched_reg) begin
            launched_reg  <= 1'b1;
            cyc_start_reg <= 1'b1;
            cyc_write_reg <= 1'b1;
            unique case (op_reg)
              OP_READ_STATUS:  cyc_data_reg <= `FLS_CMD_READ_STATUS;
              OP_CLEAR_STATUS: cyc_data_reg <= `FLS_CMD_CLEAR_STATUS;
              OP_CLEAR_LOCKS:  cyc_data_reg <= `FLS_CMD_LOCK_CLEAR_SETUP;
              OP_STS_CONFIG:   cyc_data_reg <= `FLS_CMD_STS_CONFIG;
              OP_READ_ARRAY:   cyc_data_reg <= `FLS_CMD_READ_ARRAY;
              OP_PROBE_BUFFER: cyc_data_reg <= `FLS_CMD_BUF_SETUP;
            endcase
          end else if (cyc_done) begin
            launched_reg <= 1'b0;
            unique case (op_reg)
              OP_CLEAR_LOCKS, OP_STS_CONFIG: state_reg <= ST_CMD2;
              OP_READ_STATUS, OP_PROBE_BUFFER: state_reg <= ST_READ;
              default: state_reg <= ST_IDLE;
            endcase
          end
          ST_CMD2: if (!launched_reg) begin
            // confirm for the lock clear, configuration code for the pin
            launched_reg  <= 1'b1;
            cyc_start_reg <= 1'b1;
            cyc_write_reg <= 1'b1;
            cyc_data_reg  <= (op_reg == OP_CLEAR_LOCKS) ? `FLS_CMD_CONFIRM : code_reg;
          end else if (cyc_done) begin
            launched_reg <= 1'b0;
            state_reg    <= ST_WAIT_STS;
          end
          // in level mode skip bus polling while the pin still shows busy
          ST_WAIT_STS: if (sts_mode_reg != STS_LEVEL || sts_ready) begin
            state_reg <= ST_READ;
          end
          ST_READ: if (!launched_reg) begin
            launched_reg  <= 1'b1;
            cyc_start_reg <= 1'b1;
            cyc_write_reg <= 1'b0;
          end else if (cyc_done) begin
            launched_reg <= 1'b0;
            if (op_reg == OP_PROBE_BUFFER) begin
              xsr_reg   <= cyc_rdata;
              state_reg <= ST_IDLE;
            end else begin
              sr_reg    <= cyc_rdata;
              state_reg <= (op_reg == OP_READ_STATUS) ? ST_IDLE : ST_CHECK;
            end
          end
          ST_CHECK: if (!sr_reg[`FLS_SR_READY]) begin
            state_reg <= ST_READ;  // still busy: poll again
          end else if (op_reg == OP_STS_CONFIG) begin
            if (!is_seq_err(sr_reg)) begin
              sts_mode_reg <= fls_sts_mode_t'(code_reg[1:0]);
            end
            state_reg <= ST_IDLE;
          end else begin
            // failed clear (bad sequence, low voltage or protect) keeps locks as they were
            if (!sr_reg[`FLS_SR_ERASE_ERR]) begin
              lock_unknown_reg <= 1'b0;
            end
            state_reg <= (sr_reg[`FLS_SR_ERASE_ERR] && auto_clear_reg) ? ST_CLEAR : ST_IDLE;
          end
          ST_CLEAR: if (!launched_reg) begin
            launched_reg  <= 1'b1;
            cyc_start_reg <= 1'b1;
            cyc_write_reg <= 1'b1;
            cyc_data_reg  <= `FLS_CMD_CLEAR_STATUS;
          end else if (cyc_done) begin
            launched_reg <= 1'b0;
            state_reg    <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule : fls_ctrl

// ---- bench/fls_ctrl_sva.sv ----
// port checker for the flash host controller
`timescale 1ns/100ps
module fls_ctrl_sva (
  input wire logic        core_clk_i,
  input wire logic        reset_n_i,
  input wire logic [2:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        flash_ce_n_o,
  input wire logic        flash_we_n_o,
  input wire logic        flash_oe_n_o,
  input wire logic [7:0]  flash_dq_o,
  input wire logic        flash_dq_oe_o,
  input wire logic        reset_powerdown_n_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // answer strobe and config write seen by the slave
  wire logic ack = !avs_waitrequest_o;
  wire logic cfg_wr = avs_write_i && ack && avs_address_i == 3'h1;
  // =====================================================================
  // register port
  property p_one_wait; (avs_read_i || avs_write_i) && !ack |=> ack; endproperty
  a_one_wait: assert property (p_one_wait) else $error("answer late");
  property p_wait_pulse; ack |=> !ack; endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("answer too long");
  property p_sr_valid;
    avs_read_i && ack && avs_address_i == 3'h3 |-> !avs_readdata_o[0] && (avs_readdata_o[7] || !avs_readdata_o[6:1]);
  endproperty
  a_sr_valid: assert property (p_sr_valid) else $error("status bits not masked");
  property p_xsr_rsvd; avs_read_i && ack && avs_address_i == 3'h4 |-> avs_readdata_o[6:0] == 7'h00; endproperty
  a_xsr_rsvd: assert property (p_xsr_rsvd) else $error("buffer bits not masked");
  // =====================================================================
  // flash strobes
  sequence s_we_low; (!flash_we_n_o)[*8] ##1 (!flash_we_n_o)[*5]; endsequence
  property p_we_len; $fell(flash_we_n_o) |-> s_we_low ##1 flash_we_n_o; endproperty
  a_we_len: assert property (p_we_len) else $error("write strobe length");
  property p_we_data; !flash_we_n_o |-> !flash_ce_n_o && flash_dq_oe_o && $stable(flash_dq_o); endproperty
  a_we_data: assert property (p_we_data) else $error("write data moved");
  property p_oe_ok; !flash_oe_n_o |-> !flash_ce_n_o && flash_we_n_o && !flash_dq_oe_o; endproperty
  a_oe_ok: assert property (p_oe_ok) else $error("read strobe clash");
  // pin moves at the taken edge, so the change is seen while the answer stands
  property p_rp_hold; $changed(reset_powerdown_n_o) |-> cfg_wr; endproperty
  a_rp_hold: assert property (p_rp_hold) else $error("power-down pin moved alone");
endmodule : fls_ctrl_sva

// ---- bench/fls_flash_model.sv ----
// behavioural flash device: commands, lock bits, status bytes, status pin
`timescale 1ns/100ps
module fls_flash_model (
  input  wire logic       core_clk_i,
  input  wire logic       ce_n_i,
  input  wire logic       we_n_i,
  input  wire logic       oe_n_i,
  input  wire logic [7:0] dq_i,
  input  wire logic       rp_n_i,
  input  wire logic       wp_i,
  input  wire logic       vpp_low_i,
  input  wire logic [7:0] busy_cyc_i,
  output logic      [7:0] dq_o,
  output logic            sts_o
);
  logic [7:0] sr_reg = 8'h80, pend_reg = 8'h00, lock_reg = 8'hFF, last_reg = 8'h00, val;
  logic [1:0] mode_reg = 2'd0, view_reg = 2'd0;
  logic       we_q = 1'b1;
  int         busy = 0, pulse = 0;
  // garbage in bits the host must mask; released bus never repeats the last byte
  assign val = view_reg == 2'd2 ? 8'hAB : view_reg == 2'd0 ? lock_reg : busy > 0 ? 8'h55 : sr_reg | 8'h01;
  assign dq_o = (!ce_n_i && !oe_n_i) ? val : ~last_reg;
  assign sts_o = mode_reg == 2'd0 ? busy == 0 : pulse == 0;
  // commands taken on rising write strobe, busy time counted on the clock
  always @(posedge core_clk_i) begin
    we_q <= we_n_i;
    if (!ce_n_i && !oe_n_i) last_reg <= val;
    if (!rp_n_i) begin
      if (busy > 0) lock_reg <= 8'h5A;
      busy <= 0;
      pulse <= 0;
      mode_reg <= 2'd0;
      view_reg <= 2'd0;
      pend_reg <= 8'h00;
      sr_reg <= 8'h80;
    end else begin
      if (pulse > 0) pulse <= pulse - 1;
      if (busy > 0) busy <= busy - 1;
      if (busy == 1) begin
        sr_reg[7] <= 1'b1;
        lock_reg <= 8'h00;
        if (mode_reg[0]) pulse <= 10;
      end
      if (we_n_i && !we_q && !ce_n_i) begin
        pend_reg <= 8'h00;
        view_reg <= 2'd1;
        if (pend_reg == 8'h60) begin
          if (dq_i != 8'hD0) sr_reg[5:4] <= 2'b11;
          else if (vpp_low_i) sr_reg <= sr_reg | 8'h28;
          else if (!wp_i) sr_reg <= sr_reg | 8'h22;
          else begin
            sr_reg[7] <= 1'b0;
            busy <= busy_cyc_i;
          end
        end else if (pend_reg == 8'hB8) begin
          if (dq_i > 8'h03) sr_reg[5:4] <= 2'b11;
          else mode_reg <= dq_i[1:0];
        end else begin
          case (dq_i)
            8'h50: sr_reg <= sr_reg & 8'hC5;
            8'hFF: view_reg <= 2'd0;
            8'hE8: view_reg <= 2'd2;
            8'h60, 8'hB8: pend_reg <= dq_i;
            default: ;
          endcase
        end
      end
    end
  end
endmodule : fls_flash_model

// ---- bench/fls_ctrl_tb.sv ----
// self-checking bench for the flash host controller
`timescale 1ns/100ps
module fls_ctrl_tb;
  logic        clk, rst_n, rde, wre, vpp_low, fsts, wreq, fce_n, fwe_n, foe_n, fdq_oe, frp_n, fwp;
  logic [2:0]  adr;
  logic [31:0] wdat, rdat, seed;
  logic [7:0]  fdq_o, fdq_i, busy_cyc;
  logic [63:0] exp_q[$], note;
  int          n_mismatch = 0, samples_checked = 0;
  fls_ctrl dut (.core_clk_i(clk), .reset_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rde), .avs_write_i(wre),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .flash_addr_o(), .flash_ce_n_o(fce_n),
    .flash_we_n_o(fwe_n), .flash_oe_n_o(foe_n), .flash_dq_o(fdq_o), .flash_dq_oe_o(fdq_oe), .flash_dq_i(fdq_i),
    .reset_powerdown_n_o(frp_n), .flash_wp_o(fwp), .status_output_pin_i(fsts));
  fls_flash_model u_flash (.core_clk_i(clk), .ce_n_i(fce_n), .we_n_i(fwe_n), .oe_n_i(foe_n),
    .dq_i(fdq_oe ? fdq_o : fdq_i), .rp_n_i(frp_n), .wp_i(fwp), .vpp_low_i(vpp_low), .busy_cyc_i(busy_cyc),
    .dq_o(fdq_i), .sts_o(fsts));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // a read answer takes the oldest note; a zero mask marks a poll
  always @(posedge clk) begin
    if (rde && wreq === 1'b0 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[63:32] != 32'h0) check(rdat & note[63:32], note[31:0]);
    end
  end
  // =====================================================================
  // avalon master: request held until waitrequest seen low
  // only the watchdog ends a wait, so a stuck slave counts as a failure
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    rde <= !w;
    wre <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    rde <= 1'b0;
    wre <= 1'b0;
  endtask : bus
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    exp_q.push_back({m, e});
    bus(1'b0, a, 32'h0, q);
  endtask : rd
  // poll the busy flag; no fixed wait since flash time varies
  task automatic idle();
    logic [31:0] q;
    do begin
      exp_q.push_back(64'h0);
      bus(1'b0, 3'h2, 32'h0, q);
    end while (q[0] !== 1'b0);
  endtask : idle
  task automatic op(input logic [2:0] o, input logic [7:0] c);
    wr(3'h0, {16'h0, c, 5'h0, o});
    idle();
  endtask : op
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // =====================================================================
  // main sequence
  initial begin
    seed = 32'h4615_a645;
    {rst_n, rde, wre, vpp_low, adr, wdat} = '0;
    busy_cyc = 8'h28;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(3'h1, 32'h0, 32'hFFFF_FFFF);
    rd(3'h2, 32'h0, 32'h7F);
    rd(3'h6, 32'h0, 32'hFFFF_FFFF);
    op(3'h2, 8'h00);
    rd(3'h2, 32'h08, 32'h08);
    wr(3'h2, 32'h08);
    wr(3'h1, 32'h02);
    op(3'h2, 8'h00);
    rd(3'h3, 32'hA2, 32'hFF);
    op(3'h0, 8'h00);
    rd(3'h3, 32'hA2, 32'hFF);
    op(3'h1, 8'h00);
    op(3'h0, 8'h00);
    rd(3'h3, 32'h80, 32'hFF);
    vpp_low <= 1'b1;
    op(3'h2, 8'h00);
    rd(3'h3, 32'hA8, 32'hFF);
    vpp_low <= 1'b0;
    op(3'h1, 8'h00);
    // protect low with auto clear: the failed clear is followed by a status clear
    wr(3'h1, 32'h06);
    op(3'h2, 8'h00);
    op(3'h0, 8'h00);
    rd(3'h3, 32'h80, 32'hFF);
    wr(3'h1, 32'h03);
    // each pin mode, then a lock clear seen through it
    for (int c = 0; c < 4; c++) begin
      op(3'h3, 8'(c));
      wr(3'h2, 32'h10);
      busy_cyc <= 8'd20 + 8'({$random(seed)} % 64);
      op(3'h2, 8'h00);
      rd(3'h3, 32'h80, 32'hFF);
      rd(3'h2, 32'(c * 32 + c % 2 * 16), c == 0 ? 32'h60 : 32'h70);
    end
    op(3'h3, 8'd4 + 8'({$random(seed)} % 252));
    rd(3'h2, 32'h68, 32'h68);
    wr(3'h2, 32'h0A);
    op(3'h5, 8'h00);
    rd(3'h4, 32'h80, 32'hFF);
    op(3'h4, 8'h00);
    // power-down in mid clear, then a full repeat
    busy_cyc <= 8'hC8;
    wr(3'h0, 32'h02);
    wr(3'h1, 32'h01);
    rd(3'h2, 32'h04, 32'h64);
    idle();
    wr(3'h1, 32'h03);
    busy_cyc <= 8'h30;
    op(3'h2, 8'h00);
    rd(3'h2, 32'h0, 32'h04);
    @(posedge clk);
    tally_and_finish();
  end
  // hang guard, well past the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : fls_ctrl_tb
bind fls_ctrl fls_ctrl_sva u_sva (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .flash_ce_n_o(flash_ce_n_o), .flash_we_n_o(flash_we_n_o),
  .flash_oe_n_o(flash_oe_n_o), .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o),
  .reset_powerdown_n_o(reset_powerdown_n_o));
